//--- src/mmrd_ecc.sv
// module: single-error-correcting check of data flash read words
module mmrd_ecc (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clk_en,
	mmrd_ecc_if.chk chk
);
	import mmrd_pkg::*;

	function automatic logic [MMRD_ECC_PW-1:0] mmrd_syn(input logic [MMRD_ECC_CW-1:0] c);
		logic [MMRD_ECC_PW-1:0] s;
		s = '0;
		for (int i = 1; i <= MMRD_ECC_CW; i++)
		begin
			for (int k = 0; k < MMRD_ECC_PW; k++)
			begin
				if (i[k])
					s[k] = s[k] ^ c[i-1];
			end
		end
		return s;
	endfunction

	function automatic logic [MMRD_ECC_DW-1:0] mmrd_extract(input logic [MMRD_ECC_CW-1:0] c);
		logic [MMRD_ECC_DW-1:0] d;
		int j;
		d = '0;
		j = 0;
		for (int i = 1; i <= MMRD_ECC_CW; i++)
		begin
			if ((i & (i - 1)) != 0)
			begin
				d[j] = c[i-1];
				j++;
			end
		end
		return d;
	endfunction

	localparam logic [MMRD_ECC_PW-1:0] CW_TOP = MMRD_ECC_PW'(MMRD_ECC_CW);
	localparam logic [MMRD_ECC_CW-1:0] BIT0 = MMRD_ECC_CW'(1);

	wire logic [MMRD_ECC_PW-1:0] syn = mmrd_syn(chk.code);
	wire logic single = (syn != '0) && (syn <= CW_TOP);
	wire logic [MMRD_ECC_CW-1:0] flip = single ? (BIT0 << (syn - MMRD_ECC_PW'(1))) : '0;
	wire logic [MMRD_ECC_DW-1:0] raw_data = mmrd_extract(chk.code);
	wire logic [MMRD_ECC_DW-1:0] fixed_data = mmrd_extract(chk.code ^ flip);
	logic [MMRD_ECC_DW-1:0] data_q;
	logic corr_q;
	logic unc_q;

	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			data_q <= '0;
			corr_q <= 1'b0;
			unc_q <= 1'b0;
		end
		else if (clk_en && chk.take)
		begin
			data_q <= fixed_data;
			corr_q <= single;
			unc_q <= syn > CW_TOP;
		end
	end

	assign chk.data = data_q;
	assign chk.corr = corr_q;
	assign chk.unc = unc_q;

	a_ecc_clean_pass: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && chk.take && syn == '0 |=> chk.data == $past(raw_data) && !chk.corr)
		else $error("clean data flash word altered");
	a_ecc_single_fix: assert property (@(posedge clock) disable iff (!arst_n)
		clk_en && chk.take && single |=> chk.corr && chk.data == $past(fixed_data))
		else $error("single-bit data flash error not corrected");
endmodule

//--- src/mmrd_ecc_if.sv
// interface: data flash read path between the decoder and its correction stage
interface mmrd_ecc_if;
	import mmrd_pkg::*;
	logic take;
	logic [MMRD_ECC_CW-1:0] code;
	logic [MMRD_ECC_DW-1:0] data;
	logic corr;
	logic unc;
	modport chk (input take, input code, output data, output corr, output unc);
	modport user (output take, output code, input data, input corr, input unc);
endinterface

//--- src/mmrd_periph_dec.sv
// module: fixed peripheral window decode against the system address table
module mmrd_periph_dec (
	input wire logic [mmrd_pkg::MMRD_AW-1:0] addr,
	output wire logic [mmrd_pkg::MMRD_NPER-1:0] hit
);
	import mmrd_pkg::*;

	for (genvar g = 0; g < MMRD_NPER; g++)
	begin : g_win
		assign hit[g] = (addr >= MMRD_PER_BASE[g]) && (addr <= MMRD_PER_LAST[g]);
	end
endmodule

//--- src/mmrd_pkg.sv
// package: address map, register layout, widths and states of the remap decoder
package mmrd_pkg;
	localparam int MMRD_AW = 32;
	localparam int MMRD_DW = 32;
	// post-reset map
	localparam logic [31:0] MMRD_ROM_ALIAS_END = 32'h0004_0000;
	localparam logic [31:0] MMRD_PF1_RST_BASE = 32'h0004_0000;
	localparam logic [31:0] MMRD_PF2_RST_BASE = 32'h0004_8000;
	// normal map
	localparam logic [31:0] MMRD_PF_LO_BASE = 32'h0000_0000;
	localparam logic [31:0] MMRD_PF_HI_BASE = 32'h0000_8000;
	localparam logic [31:0] MMRD_ROM_NRM_BASE = 32'h0002_0000;
	// both maps
	localparam logic [31:0] MMRD_DFL_BASE = 32'h0006_8800;
	localparam logic [31:0] MMRD_DFL_LAST = 32'h0006_8fff;
	localparam logic [31:0] MMRD_RAM_BASE = 32'h0006_9000;
	localparam logic [31:0] MMRD_RAM_LAST = 32'h0006_9fff;
	// region size codes: span is 1 kB shifted left by the code
	localparam int MMRD_SZ_W = 4;
	localparam int MMRD_SZ_LSB = 10;
	localparam logic [3:0] MMRD_SZ_MAX = 4'he;
	localparam logic [3:0] MMRD_SZ_ROM = 4'h3;
	localparam logic [3:0] MMRD_SZ_PF = 4'h5;
	localparam logic [3:0] MMRD_SZ_DFL = 4'h1;
	localparam logic [3:0] MMRD_SZ_RAM = 4'h2;
	localparam int MMRD_NREG = 5;
	localparam int MMRD_R_ROM = 0;
	localparam int MMRD_R_PF1 = 1;
	localparam int MMRD_R_PF2 = 2;
	localparam int MMRD_R_DFL = 3;
	localparam int MMRD_R_RAM = 4;
	localparam int MMRD_SIZE_W = MMRD_SZ_W * MMRD_NREG;
	localparam logic [19:0] MMRD_SIZE_RST = {MMRD_SZ_RAM, MMRD_SZ_DFL, MMRD_SZ_PF, MMRD_SZ_PF,
		MMRD_SZ_ROM};
	// memory word organisation
	localparam int MMRD_WORD_LSB = 2;
	localparam int MMRD_ROM_WW = 11;
	localparam int MMRD_PF_WW = 13;
	localparam int MMRD_DFL_WW = 9;
	localparam int MMRD_RAM_WW = 10;
	localparam int MMRD_PF_PAGE_LSB = 10;
	localparam int MMRD_PF_PAGE_W = 5;
	localparam int MMRD_DFL_PAGE_LSB = 5;
	localparam int MMRD_DFL_PAGE_W = 6;
	// decoder registers inside its own window
	localparam int MMRD_OFS_W = 8;
	localparam logic [7:0] MMRD_REG_CTL = 8'h00;
	localparam logic [7:0] MMRD_REG_SIZE = 8'h04;
	localparam logic [7:0] MMRD_REG_STAT = 8'h08;
	localparam int MMRD_CTL_REMAP = 0;
	localparam int MMRD_CTL_BANK = 1;
	localparam int MMRD_STAT_CORR = 0;
	localparam int MMRD_STAT_UNC = 1;
	// data flash check code
	localparam int MMRD_ECC_DW = 32;
	localparam int MMRD_ECC_CW = 38;
	localparam int MMRD_ECC_PW = 6;
	// peripheral windows
	localparam int MMRD_NPER = 24;
	localparam int MMRD_PER_DEC = 20;
	localparam logic [31:0] MMRD_PER_BASE [MMRD_NPER] = '{
		32'h0012_0000, 32'h0013_0000, 32'h0014_0000, 32'h0015_0000, 32'h0016_0000,
		32'h0017_0000, 32'h0018_0000, 32'h0019_0000, 32'h001a_0000, 32'h001b_0000,
		32'h001c_0000, 32'h001d_0000, 32'h001e_0000, 32'hfff7_ec00, 32'hfff7_ed00,
		32'hfff7_f000, 32'hfff7_f600, 32'hfff7_fa00, 32'hfff7_fd00, 32'hffff_fd00,
		32'hffff_fe00, 32'hffff_ff20, 32'hffff_ff40, 32'hffff_ffd0};
	localparam logic [31:0] MMRD_PER_LAST [MMRD_NPER] = '{
		32'h0012_00ff, 32'h0013_00ff, 32'h0014_00ff, 32'h0015_00ff, 32'h0016_00ff,
		32'h0017_00ff, 32'h0018_00ff, 32'h0019_00ff, 32'h001a_00ff, 32'h001b_00ff,
		32'h001c_00ff, 32'h001d_00ff, 32'h001e_00ff, 32'hfff7_ecff, 32'hfff7_edff,
		32'hfff7_f0ff, 32'hfff7_f6ff, 32'hfff7_faff, 32'hfff7_fdff, 32'hffff_fdff,
		32'hffff_feff, 32'hffff_ff37, 32'hffff_ff50, 32'hffff_ffec};
	localparam logic [23:0] MMRD_PER_DEC_BIT = 24'h10_0000;
	typedef enum logic [1:0] {
		MMRD_ST_IDLE = 2'b00,
		MMRD_ST_ACC = 2'b01
	} mmrd_acc_t;
endpackage

//--- src/mmrd_top.sv
// module: memory select unit with post-reset and normal maps and its config registers
module mmrd_top (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic bus_req,
	input wire logic bus_write,
	input wire logic bus_priv,
	input wire logic [mmrd_pkg::MMRD_AW-1:0] bus_addr,
	input wire logic [mmrd_pkg::MMRD_DW-1:0] bus_wdata,
	output wire logic bus_wait,
	output wire logic [mmrd_pkg::MMRD_DW-1:0] reg_rdata,
	output wire logic reg_rvalid,
	output wire logic sel_rom,
	output wire logic sel_pf1,
	output wire logic sel_pf2,
	output wire logic sel_dfl,
	output wire logic sel_ram,
	output wire logic [mmrd_pkg::MMRD_NPER-1:0] sel_periph,
	output wire logic mem_write,
	output wire logic [mmrd_pkg::MMRD_PF_WW-1:0] mem_word,
	output wire logic [mmrd_pkg::MMRD_PF_PAGE_W-1:0] pf_page,
	output wire logic [mmrd_pkg::MMRD_DFL_PAGE_W-1:0] dfl_page,
	input wire logic [mmrd_pkg::MMRD_ECC_CW-1:0] dfl_code,
	output wire logic [mmrd_pkg::MMRD_ECC_DW-1:0] dfl_rdata,
	output wire logic dfl_rvalid,
	output wire logic map_normal,
	output wire logic map_bank
);
	import mmrd_pkg::*;

	function automatic logic [3:0] mmrd_clamp(input logic [3:0] code);
		return (code > MMRD_SZ_MAX) ? MMRD_SZ_MAX : code;
	endfunction

	function automatic logic mmrd_in(input logic [31:0] a, input logic [31:0] base,
		input logic [3:0] code);
		logic [31:0] m;
		m = {MMRD_AW{1'b1}} << (MMRD_SZ_LSB + int'(mmrd_clamp(code)));
		return (a & m) == (base & m);
	endfunction

	function automatic logic [MMRD_PF_WW-1:0] mmrd_wmask(input int w);
		return ~({MMRD_PF_WW{1'b1}} << w);
	endfunction

	mmrd_acc_t st_q;
	mmrd_acc_t st_d;
	logic remap_q;
	logic bank_q;
	logic [MMRD_SIZE_W-1:0] size_q;
	logic stat_corr_q;
	logic stat_unc_q;
	logic [MMRD_DW-1:0] rdata_q;
	logic rvalid_q;
	logic sel_rom_q;
	logic sel_pf1_q;
	logic sel_pf2_q;
	logic sel_dfl_q;
	logic sel_ram_q;
	logic [MMRD_NPER-1:0] sel_per_q;
	logic write_q;
	logic [MMRD_PF_WW-1:0] word_q;
	logic [MMRD_PF_PAGE_W-1:0] pf_page_q;
	logic [MMRD_DFL_PAGE_W-1:0] dfl_page_q;
	logic ecc_vld_q;
	logic [MMRD_DW-1:0] ctl_word;
	logic [MMRD_DW-1:0] size_word;
	logic [MMRD_DW-1:0] stat_word;
	wire logic [MMRD_NPER-1:0] per_hit;

	mmrd_ecc_if ecc_bus();

	mmrd_periph_dec u_periph (
		.addr(bus_addr),
		.hit(per_hit)
	);

	mmrd_ecc u_ecc (
		.clock(clock),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.chk(ecc_bus)
	);

	// region sizes
	wire logic [3:0] sz_rom = size_q[MMRD_R_ROM*MMRD_SZ_W +: MMRD_SZ_W];
	wire logic [3:0] sz_pf1 = size_q[MMRD_R_PF1*MMRD_SZ_W +: MMRD_SZ_W];
	wire logic [3:0] sz_pf2 = size_q[MMRD_R_PF2*MMRD_SZ_W +: MMRD_SZ_W];
	wire logic [3:0] sz_dfl = size_q[MMRD_R_DFL*MMRD_SZ_W +: MMRD_SZ_W];
	wire logic [3:0] sz_ram = size_q[MMRD_R_RAM*MMRD_SZ_W +: MMRD_SZ_W];
	wire logic [3:0] sz_lo = bank_q ? sz_pf2 : sz_pf1;
	wire logic [3:0] sz_hi = bank_q ? sz_pf1 : sz_pf2;

	// region hits
	wire logic rom_rst_hit = bus_addr < MMRD_ROM_ALIAS_END;
	wire logic rom_nrm_hit = mmrd_in(bus_addr, MMRD_ROM_NRM_BASE, sz_rom);
	wire logic pf1_rst_hit = mmrd_in(bus_addr, MMRD_PF1_RST_BASE, sz_pf1);
	wire logic pf2_rst_hit = mmrd_in(bus_addr, MMRD_PF2_RST_BASE, sz_pf2);
	wire logic lo_hit = mmrd_in(bus_addr, MMRD_PF_LO_BASE, sz_lo);
	wire logic hi_hit = mmrd_in(bus_addr, MMRD_PF_HI_BASE, sz_hi) && !lo_hit;
	wire logic dfl_hit = mmrd_in(bus_addr, MMRD_DFL_BASE, sz_dfl);
	wire logic ram_hit = mmrd_in(bus_addr, MMRD_RAM_BASE, sz_ram);

	// map selection, first match wins
	wire logic rom_sel_d = remap_q ? (rom_nrm_hit && !lo_hit && !hi_hit) : rom_rst_hit;
	wire logic pf1_sel_d = remap_q ? (bank_q ? hi_hit : lo_hit)
		: (pf1_rst_hit && !rom_rst_hit);
	wire logic pf2_sel_d = remap_q ? (bank_q ? lo_hit : hi_hit)
		: (pf2_rst_hit && !rom_rst_hit && !pf1_rst_hit);
	wire logic mem_hi = rom_sel_d || pf1_sel_d || pf2_sel_d;
	wire logic dfl_sel_d = dfl_hit && !mem_hi;
	wire logic ram_sel_d = ram_hit && !mem_hi && !dfl_hit;
	wire logic mem_any = mem_hi || dfl_hit || ram_hit;
	wire logic dec_hit = per_hit[MMRD_PER_DEC] && !mem_any;
	wire logic [MMRD_NPER-1:0] per_sel_d = per_hit & ~MMRD_PER_DEC_BIT
		& {MMRD_NPER{!mem_any}};

	// memory access and word organisation
	wire logic acc = bus_req && !dec_hit;
	wire logic [MMRD_PF_WW-1:0] word_raw = bus_addr[MMRD_WORD_LSB +: MMRD_PF_WW];
	wire logic [MMRD_PF_WW-1:0] word_msk = rom_sel_d ? mmrd_wmask(MMRD_ROM_WW)
		: dfl_sel_d ? mmrd_wmask(MMRD_DFL_WW)
		: ram_sel_d ? mmrd_wmask(MMRD_RAM_WW)
		: mmrd_wmask(MMRD_PF_WW);
	wire logic [MMRD_PF_PAGE_W-1:0] pf_page_d = bus_addr[MMRD_PF_PAGE_LSB +: MMRD_PF_PAGE_W];
	wire logic [MMRD_DFL_PAGE_W-1:0] dfl_page_d =
		bus_addr[MMRD_DFL_PAGE_LSB +: MMRD_DFL_PAGE_W];
	wire logic [MMRD_ROM_WW-1:0] rom_word = bus_addr[MMRD_WORD_LSB +: MMRD_ROM_WW];

	// decoder register access
	wire logic reg_req = bus_req && dec_hit;
	wire logic reg_go = reg_req && (st_q == MMRD_ST_ACC);
	wire logic reg_wr_ok = reg_go && bus_write && bus_priv;
	wire logic [MMRD_OFS_W-1:0] ofs = bus_addr[MMRD_OFS_W-1:0];
	wire logic wr_ctl = reg_wr_ok && (ofs == MMRD_REG_CTL);
	wire logic wr_size = reg_wr_ok && (ofs == MMRD_REG_SIZE);
	wire logic wr_stat = reg_wr_ok && (ofs == MMRD_REG_STAT);
	wire logic wd_remap = bus_wdata[MMRD_CTL_REMAP];
	// firmware flips map and bank in one write; until then the ROM map holds
	wire logic remap_d = wr_ctl ? wd_remap : remap_q;
	wire logic bank_d = wr_ctl ? bus_wdata[MMRD_CTL_BANK] : bank_q;
	wire logic [MMRD_SIZE_W-1:0] size_d = wr_size ? bus_wdata[MMRD_SIZE_W-1:0] : size_q;
	wire logic corr_clr = wr_stat && bus_wdata[MMRD_STAT_CORR];
	wire logic unc_clr = wr_stat && bus_wdata[MMRD_STAT_UNC];
	// a correction event in the clearing cycle keeps the flag
	wire logic stat_corr_d = (ecc_vld_q && ecc_bus.corr) || (stat_corr_q && !corr_clr);
	wire logic stat_unc_d = (ecc_vld_q && ecc_bus.unc) || (stat_unc_q && !unc_clr);
	wire logic [MMRD_DW-1:0] rdata_d = (ofs == MMRD_REG_CTL) ? ctl_word
		: (ofs == MMRD_REG_SIZE) ? size_word
		: (ofs == MMRD_REG_STAT) ? stat_word
		: '0;

	assign bus_wait = reg_req && (st_q == MMRD_ST_IDLE);

	always_comb
	begin
		ctl_word = '0;
		ctl_word[MMRD_CTL_REMAP] = remap_q;
		ctl_word[MMRD_CTL_BANK] = bank_q;
		size_word = '0;
		size_word[MMRD_SIZE_W-1:0] = size_q;
		stat_word = '0;
		stat_word[MMRD_STAT_CORR] = stat_corr_q;
		stat_word[MMRD_STAT_UNC] = stat_unc_q;
	end

	always_comb
	begin
		st_d = st_q;
		unique case (st_q)
			MMRD_ST_IDLE:
				if (reg_req)
					st_d = MMRD_ST_ACC;
			MMRD_ST_ACC:
				st_d = MMRD_ST_IDLE;
			default:
				st_d = MMRD_ST_IDLE;
		endcase
	end

	// control registers
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= MMRD_ST_IDLE;
			remap_q <= 1'b0;
			bank_q <= 1'b0;
			size_q <= MMRD_SIZE_RST;
			stat_corr_q <= 1'b0;
			stat_unc_q <= 1'b0;
			rdata_q <= '0;
			rvalid_q <= 1'b0;
		end
		else if (clk_en)
		begin
			st_q <= st_d;
			remap_q <= remap_d;
			bank_q <= bank_d;
			size_q <= size_d;
			stat_corr_q <= stat_corr_d;
			stat_unc_q <= stat_unc_d;
			rdata_q <= (reg_go && !bus_write) ? rdata_d : rdata_q;
			rvalid_q <= reg_go && !bus_write;
		end
	end

	// registered selects
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sel_rom_q <= 1'b0;
			sel_pf1_q <= 1'b0;
			sel_pf2_q <= 1'b0;
			sel_dfl_q <= 1'b0;
			sel_ram_q <= 1'b0;
			sel_per_q <= '0;
			write_q <= 1'b0;
		end
		else if (clk_en)
		begin
			sel_rom_q <= acc && rom_sel_d;
			sel_pf1_q <= acc && pf1_sel_d;
			sel_pf2_q <= acc && pf2_sel_d;
			sel_dfl_q <= acc && dfl_sel_d;
			sel_ram_q <= acc && ram_sel_d;
			sel_per_q <= acc ? per_sel_d : '0;
			write_q <= acc && bus_write;
		end
	end

	// registered word and page indices
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			word_q <= '0;
			pf_page_q <= '0;
			dfl_page_q <= '0;
			ecc_vld_q <= 1'b0;
		end
		else if (clk_en)
		begin
			word_q <= acc ? (word_raw & word_msk) : word_q;
			pf_page_q <= acc ? pf_page_d : pf_page_q;
			dfl_page_q <= acc ? dfl_page_d : dfl_page_q;
			ecc_vld_q <= ecc_bus.take;
		end
	end

	assign ecc_bus.take = sel_dfl_q && !write_q;
	assign ecc_bus.code = dfl_code;
	assign dfl_rdata = ecc_bus.data;
	assign dfl_rvalid = ecc_vld_q;
	assign reg_rdata = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign sel_rom = sel_rom_q;
	assign sel_pf1 = sel_pf1_q;
	assign sel_pf2 = sel_pf2_q;
	assign sel_dfl = sel_dfl_q;
	assign sel_ram = sel_ram_q;
	assign sel_periph = sel_per_q;
	assign mem_write = write_q;
	assign mem_word = word_q;
	assign pf_page = pf_page_q;
	assign dfl_page = dfl_page_q;
	assign map_normal = remap_q;
	assign map_bank = bank_q;

	// checks
	wire logic sel_any = sel_rom_q || sel_pf1_q || sel_pf2_q || sel_dfl_q || sel_ram_q
		|| (|sel_per_q);
	wire logic dfl_blk = (bus_addr >= MMRD_DFL_BASE) && (bus_addr <= MMRD_DFL_LAST);
	wire logic gap_blk = (bus_addr > MMRD_RAM_LAST) && (bus_addr < MMRD_PER_BASE[0]);
	wire logic size_dflt = size_q == MMRD_SIZE_RST;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	a_rom_reset_alias: assert property (
		clk_en && acc && !remap_q && rom_rst_hit
		|=> sel_rom_q && !sel_pf1_q && mem_word[MMRD_ROM_WW-1:0] == $past(rom_word))
		else $error("boot ROM alias not selected in post-reset map");
	a_flash_reset_place: assert property (
		clk_en && acc && !remap_q && size_dflt && bus_addr >= MMRD_PF1_RST_BASE
		&& bus_addr < MMRD_PF2_RST_BASE |=> sel_pf1_q && !sel_pf2_q && !sel_rom_q)
		else $error("bank one not at its post-reset place");
	a_data_fixed: assert property (
		clk_en && acc && size_dflt && dfl_blk |=> sel_dfl_q && !sel_ram_q)
		else $error("data flash not selected at its fixed place");
	a_bank_low_place: assert property (
		clk_en && acc && remap_q && size_dflt && bus_addr < MMRD_PF_HI_BASE
		|=> ($past(bank_q) ? sel_pf2_q : sel_pf1_q) && !sel_rom_q)
		else $error("wrong flash bank at address zero");
	a_rom_moved: assert property (
		clk_en && acc && remap_q && sz_rom <= MMRD_SZ_ROM && bus_addr < MMRD_ROM_NRM_BASE
		|=> !sel_rom_q)
		else $error("boot ROM still decoded below its normal base");
	a_gap_no_select: assert property (
		clk_en && acc && size_dflt && gap_blk |=> !sel_any)
		else $error("select asserted for an unmapped address");
	a_wait_one: assert property (
		clk_en && reg_req && st_q == MMRD_ST_IDLE |-> bus_wait ##1 st_q == MMRD_ST_ACC)
		else $error("decoder register access without one wait state");
	a_user_write_ignored: assert property (
		clk_en && reg_go && bus_write && !bus_priv |=> $stable(ctl_word) && $stable(size_q))
		else $error("user mode write changed decoder registers");
	a_priv_remap: assert property (
		clk_en && wr_ctl |=> remap_q == $past(wd_remap) && map_normal == remap_q)
		else $error("privileged map write not taken");
endmodule

//--- tb/mmrd_cpu_model.sv
// bus master model: processor core issuing single accesses on the shared bus
module mmrd_cpu_model (
	input wire logic clock,
	input wire logic bus_wait,
	output logic bus_req,
	output logic bus_write,
	output logic bus_priv,
	output logic [mmrd_pkg::MMRD_AW-1:0] bus_addr,
	output logic [mmrd_pkg::MMRD_DW-1:0] bus_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	int waited;
	initial
	begin
		bus_req = 1'b0;
		bus_write = 1'b0;
		bus_priv = 1'b0;
		bus_addr = '0;
		bus_wdata = '0;
		waited = 0;
	end
	// request held until taken or for at most four wait cycles; returns just after the taking edge
	task automatic access(input logic [31:0] a, input logic w, input logic [31:0] d,
		input logic p);
		@(posedge clock);
		bus_req <= 1'b1;
		bus_write <= w;
		bus_priv <= p;
		bus_addr <= a;
		bus_wdata <= d;
		waited = 0;
		@(posedge clock);
		while (bus_wait === 1'b1 && waited < 4)
		begin
			waited++;
			@(posedge clock);
		end
		bus_req <= 1'b0;
		bus_write <= 1'b0;
		bus_addr <= ~a;
		bus_wdata <= ~d;
		#1;
	endtask
endmodule

//--- tb/testbench.sv
// testbench: map decode, remap control, decoder registers and data flash correction
module testbench import mmrd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, arst_n, clk_en, bus_req, bus_write, bus_priv, bus_wait, reg_rvalid;
	logic [31:0] bus_addr, bus_wdata, reg_rdata, dfl_rdata;
	logic sel_rom, sel_pf1, sel_pf2, sel_dfl, sel_ram, mem_write, dfl_rvalid;
	logic map_normal, map_bank, nrm, bk;
	logic [23:0] sel_periph;
	logic [12:0] mem_word;
	logic [4:0] pf_page;
	logic [5:0] dfl_page;
	logic [37:0] dfl_code, cw;
	logic [31:0] d;
	int failures, compares;
	logic [31:0] corner [31] = '{32'h0, 32'h3fffc, 32'h40000, 32'h47ffc, 32'h48000,
		32'h4fffc, 32'h50000, 32'h7ffc, 32'h8000, 32'hfffc, 32'h10000, 32'h20000,
		32'h21ffc, 32'h22000, 32'h68800, 32'h68ffc, 32'h69000, 32'h69ffc, 32'h6a000,
		32'h120000, 32'h1200fc, 32'h120100, 32'h1e00fc, 32'hfff7ec00, 32'hfffffd00,
		32'hffffff20, 32'hffffff34, 32'hffffff50, 32'hffffffd0, 32'hffffffec, 32'hfffffff0};
	mmrd_cpu_model cpu (.clock(clock), .bus_wait(bus_wait), .bus_req(bus_req),
		.bus_write(bus_write), .bus_priv(bus_priv), .bus_addr(bus_addr), .bus_wdata(bus_wdata));
	mmrd_top DUT (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .bus_req(bus_req),
		.bus_write(bus_write), .bus_priv(bus_priv), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wait(bus_wait), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .sel_rom(sel_rom), .sel_pf1(sel_pf1), .sel_pf2(sel_pf2),
		.sel_dfl(sel_dfl), .sel_ram(sel_ram), .sel_periph(sel_periph), .mem_write(mem_write),
		.mem_word(mem_word), .pf_page(pf_page), .dfl_page(dfl_page), .dfl_code(dfl_code),
		.dfl_rdata(dfl_rdata), .dfl_rvalid(dfl_rvalid), .map_normal(map_normal),
		.map_bank(map_bank));
	always #20 clock = ~clock;
	function automatic logic [28:0] exp_sel(input logic [31:0] a, input logic n, input logic b);
		logic [28:0] e;
		e = '0;
		if (!n)
		begin
			if (a < 32'h0004_0000) e[0] = 1'b1;
			else if (a[31:15] == 17'h8) e[1] = 1'b1;
			else if (a[31:15] == 17'h9) e[2] = 1'b1;
		end
		else
		begin
			if (a[31:15] == 17'h0) e[b ? 2 : 1] = 1'b1;
			else if (a[31:15] == 17'h1) e[b ? 1 : 2] = 1'b1;
			else if (a[31:13] == 19'h10) e[0] = 1'b1;
		end
		if (a[31:11] == 21'hd1) e[3] = 1'b1;
		if (a[31:12] == 20'h69) e[4] = 1'b1;
		for (int i = 0; i < MMRD_NPER; i++)
			if (i != 20 && a >= MMRD_PER_BASE[i] && a <= MMRD_PER_LAST[i]) e[5+i] = 1'b1;
		return e;
	endfunction
	function automatic logic [37:0] enc(input logic [31:0] v);
		logic [37:0] c;
		int k;
		c = '0;
		k = 0;
		for (int p = 1; p <= 38; p++)
			if ((p & (p - 1)) != 0)
			begin
				c[p-1] = v[k];
				k++;
			end
		for (int b = 0; b < 6; b++)
			for (int p = 1; p <= 38; p++)
				if (p[b] && (p & (p - 1)) != 0) c[(1 << b) - 1] ^= c[p-1];
		return c;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic mem(input logic [31:0] a);
		logic [28:0] e;
		logic [12:0] w;
		logic wb;
		e = exp_sel(a, nrm, bk);
		w = a[14:2];
		if (e[0]) w[12:11] = 2'b0;
		if (e[3]) w[12:9] = 4'b0;
		if (e[4]) w[12:10] = 3'b0;
		wb = 1'($urandom);
		cpu.access(a, wb, $urandom, 1'b1);
		check({sel_periph, sel_ram, sel_dfl, sel_pf2, sel_pf1, sel_rom}, e);
		check(mem_word, w);
		check(pf_page, a[14:10]);
		check(dfl_page, a[10:5]);
		check(mem_write, wb);
		check(cpu.waited, 0);
	endtask
	task automatic phase();
		foreach (corner[i]) mem(corner[i]);
		repeat (20) mem($urandom & 32'h0007_fffc);
	endtask
	task automatic wr(input logic [7:0] o, input logic [31:0] v, input logic p);
		cpu.access({24'hffff_fe, o}, 1'b1, v, p);
		check(cpu.waited, 1);
	endtask
	task automatic rd(input logic [7:0] o, input logic [31:0] e);
		cpu.access({24'hffff_fe, o}, 1'b0, $urandom, 1'b0);
		check(cpu.waited, 1);
		check(reg_rvalid, 1'b1);
		check(reg_rdata, e);
	endtask
	task automatic complete_run();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		#400000;
		failures++;
		complete_run();
	end
	initial
	begin
		clock = 1'b0;
		arst_n = 1'b0;
		clk_en = 1'b1;
		dfl_code = '0;
		nrm = 1'b0;
		bk = 1'b0;
		failures = 0;
		compares = 0;
		void'($urandom(32'hcf968383));
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		rd(MMRD_REG_SIZE, 32'h21553);
		rd(MMRD_REG_CTL, 32'h0);
		phase();
		wr(MMRD_REG_CTL, 32'h1, 1'b0);
		check(map_normal, 1'b0);
		wr(MMRD_REG_CTL, 32'h1, 1'b1);
		nrm = 1'b1;
		check(map_normal, 1'b1);
		phase();
		wr(MMRD_REG_CTL, 32'h3, 1'b1);
		bk = 1'b1;
		check({map_normal, map_bank}, 2'b11);
		rd(MMRD_REG_CTL, 32'h3);
		phase();
		rd(8'h0c, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			d = $urandom;
			cw = enc(d);
			if (i > 0) cw[$urandom_range(37)] ^= 1'b1;
			@(posedge clock);
			dfl_code <= cw;
			cpu.access(32'h0006_8800 | ($urandom & 32'h7fc), 1'b0, 32'h0, 1'b1);
			check(sel_dfl, 1'b1);
			@(posedge clock);
			#1;
			check(dfl_rvalid, 1'b1);
			check(dfl_rdata, d);
		end
		rd(MMRD_REG_STAT, 32'h1);
		wr(MMRD_REG_STAT, 32'h1, 1'b1);
		rd(MMRD_REG_STAT, 32'h0);
		// two flipped bits give a syndrome above the codeword length
		@(posedge clock);
		dfl_code <= 38'h01_4000_0000;
		cpu.access(32'h0006_8800, 1'b0, 32'h0, 1'b1);
		@(posedge clock);
		#1;
		check(dfl_rvalid, 1'b1);
		check(dfl_rdata, 32'h0600_0000);
		rd(MMRD_REG_STAT, 32'h2);
		wr(MMRD_REG_SIZE, 32'h31553, 1'b1);
		cpu.access(32'h0006_8000, 1'b0, 32'h0, 1'b1);
		check(sel_ram, 1'b1);
		mem(32'h0000_0010);
		// clock enable low: the access is not taken and the word index holds
		@(posedge clock);
		clk_en <= 1'b0;
		cpu.access(32'h0000_0020, 1'b0, 32'h0, 1'b1);
		check(sel_pf2, 1'b0);
		check(mem_word, 32'h4);
		@(posedge clock);
		clk_en <= 1'b1;
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		nrm = 1'b0;
		bk = 1'b0;
		#1;
		check({map_normal, map_bank}, 2'b00);
		phase();
		complete_run();
	end
endmodule
